// >>> include/lco_defs.svh
// constants for the loop current output controller
`ifndef LCO_DEFS_SVH
`define LCO_DEFS_SVH
`define LCO_AW 8
`define LCO_OFF_CTRL 8'h00
`define LCO_OFF_LOW 8'h04
`define LCO_OFF_HIGH 8'h08
`define LCO_OFF_SEL 8'h0C
`define LCO_OFF_STAT 8'h10
`define LCO_CTRL_EN 0
`define LCO_CTRL_FSEL_LO 1
`define LCO_CTRL_FSEL_HI 2
`define LCO_SEL_SH_HI 4
`define LCO_STAT_FLT 16
`define LCO_STAT_BRK 17
`define LCO_STAT_EN 18
`define LCO_RESP_OKAY 2'h0
`define LCO_RESP_SLVERR 2'h2
`define LCO_UA_DIS 16'h0DAC
`define LCO_UA_3M6 16'h0E10
`define LCO_UA_MIN 16'h0ED8
`define LCO_UA_LOW 16'h0FA0
`define LCO_UA_SPAN 16'h3E80
`define LCO_UA_HIGH 16'h4E20
`define LCO_UA_MAX 16'h5014
`define LCO_UA_21M 16'h5208
`define LCO_UA_SAT 16'h4268
`define LCO_OHM_3W_LO 16'h0005
`define LCO_OHM_3W_HI 16'h01F4
`define LCO_OHM_2W_LO 16'h000A
`define LCO_OHM_2W_HI 16'h0226
`endif

// >>> include/lco_pkg.sv
// types for the loop current output controller
`default_nettype none
package lco_pkg;
    typedef enum logic [1:0] {LCO_IN_LOOP = 2'h0, LCO_IN_VOLT = 2'h1, LCO_IN_RTD = 2'h2} lco_in_t;
    typedef enum logic [1:0] {LCO_W3 = 2'h0, LCO_W2 = 2'h1, LCO_WDIFF = 2'h2} lco_wire_t;
    typedef enum logic [1:0] {LCO_F_OFF = 2'h0, LCO_F_3M6 = 2'h1, LCO_F_3M8 = 2'h2,
        LCO_F_21M = 2'h3} lco_fsel_t;
    typedef enum logic [1:0] {LCO_S_IDLE = 2'h0, LCO_S_RUN = 2'h1, LCO_S_DONE = 2'h3} lco_st_t;
endpackage
`default_nettype wire

// >>> core/lco_top.sv
// loop current output controller with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "lco_defs.svh"
module lco_top #(
    parameter int DW = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`LCO_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`LCO_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [DW-1:0] display_value,
    input wire lco_pkg::lco_in_t input_type,
    input wire lco_pkg::lco_wire_t rtd_wiring,
    input wire logic [15:0] rtd_resistance,
    input wire logic input_break_flag,
    input wire logic input_cal_changed,
    output logic [15:0] loop_current_ua,
    output logic sensor_fault
);
    import lco_pkg::*;

    localparam int NW = DW + 15;

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wdata_q;
    logic [3:0] wstrb_q;
    logic [`LCO_AW-1:0] awaddr_q;
    logic aw_full_q, w_full_q, wr_fire;
    logic en_q;
    lco_fsel_t fsel_q;
    logic [31:0] low_q, high_q, sel_q;
    logic rtd_fault_q;
    logic [15:0] out_q, out_d;
    logic signed [15:0] lin_q;
    lco_st_t st_q;
    logic [5:0] cnt_q;
    logic [NW-1:0] quo_q;
    logic [DW+1:0] rem_q;
    logic [DW:0] div_q, diff_q;
    logic neg_q;
    logic signed [DW-1:0] portion;
    logic signed [DW:0] diff, den;
    logic [DW:0] dmag, nmag;
    logic [DW+1:0] rem_sh;
    logic [15:0] qsat;
    logic brk_force, flt_force;
    logic [31:0] rd_d;
    logic rd_ok, wr_ok;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign loop_current_ua = out_q;
    assign sensor_fault = rtd_fault_q;

    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_ok = awaddr_q == `LCO_OFF_CTRL || awaddr_q == `LCO_OFF_LOW
        || awaddr_q == `LCO_OFF_HIGH || awaddr_q == `LCO_OFF_SEL || awaddr_q == `LCO_OFF_STAT;

    // write channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `LCO_RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else
        begin
            if (awvalid && awready_q)
            begin
                awaddr_q <= awaddr;
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (wvalid && wready_q)
            begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `LCO_RESP_OKAY : `LCO_RESP_SLVERR;
            end
            if (bvalid_q && bready)
            begin
                bvalid_q <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // read data mux
    always_comb
    begin
        rd_d = '0;
        rd_ok = 1'b1;
        unique case (araddr)
            `LCO_OFF_CTRL: rd_d = {29'h0, fsel_q, en_q};
            `LCO_OFF_LOW: rd_d = {{(32-DW){1'b0}}, low_q[DW-1:0]};
            `LCO_OFF_HIGH: rd_d = {{(32-DW){1'b0}}, high_q[DW-1:0]};
            `LCO_OFF_SEL: rd_d = {27'h0, sel_q[`LCO_SEL_SH_HI:0]};
            `LCO_OFF_STAT: rd_d = {13'h0, en_q, brk_force, rtd_fault_q, out_q};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `LCO_RESP_OKAY;
        end
        else if (arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= rd_ok ? `LCO_RESP_OKAY : `LCO_RESP_SLVERR;
        end
        else if (rvalid_q && rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // enable: calibration change wins over a software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            en_q <= 1'b0;
        else if (input_cal_changed)
            en_q <= 1'b0;
        else if (wr_fire && awaddr_q == `LCO_OFF_CTRL && wstrb_q[0])
            en_q <= wdata_q[`LCO_CTRL_EN];
    end

    // endpoints and portion select, untouched by the enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fsel_q <= LCO_F_OFF;
            low_q <= '0;
            high_q <= '0;
            sel_q <= '0;
        end
        else if (wr_fire)
        begin
            if (awaddr_q == `LCO_OFF_CTRL && wstrb_q[0])
                fsel_q <= lco_fsel_t'(wdata_q[`LCO_CTRL_FSEL_HI:`LCO_CTRL_FSEL_LO]);
            if (awaddr_q == `LCO_OFF_LOW)
                low_q <= merge(low_q, wdata_q, wstrb_q);
            if (awaddr_q == `LCO_OFF_HIGH)
                high_q <= merge(high_q, wdata_q, wstrb_q);
            if (awaddr_q == `LCO_OFF_SEL)
                sel_q <= merge(sel_q, wdata_q, wstrb_q);
        end
    end

    // sensor fault limits per wiring
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rtd_fault_q <= 1'b0;
        else if (rtd_wiring == LCO_W3)
            rtd_fault_q <= rtd_resistance < `LCO_OHM_3W_LO || rtd_resistance > `LCO_OHM_3W_HI;
        else
            rtd_fault_q <= rtd_resistance < `LCO_OHM_2W_LO || rtd_resistance > `LCO_OHM_2W_HI;
    end

    // portion of display and operands
    assign portion = $signed(display_value) >>> sel_q[`LCO_SEL_SH_HI:0];
    assign diff = DW'(portion) - $signed({low_q[DW-1], low_q[DW-1:0]});
    assign den = $signed({high_q[DW-1], high_q[DW-1:0]}) - $signed({low_q[DW-1], low_q[DW-1:0]});
    assign dmag = den[DW] ? (DW+1)'(-den) : den;
    assign nmag = diff[DW] ? (DW+1)'(-diff) : diff;
    assign rem_sh = {rem_q[DW:0], quo_q[NW-1]};
    assign qsat = (quo_q > NW'(`LCO_UA_SAT)) ? `LCO_UA_SAT : quo_q[15:0];

    // sequential divide: (portion-low)*span/(high-low)
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= LCO_S_IDLE;
            cnt_q <= '0;
            quo_q <= '0;
            rem_q <= '0;
            div_q <= '0;
            diff_q <= '0;
            neg_q <= 1'b0;
            lin_q <= $signed(`LCO_UA_LOW);
        end
        else
        begin
            unique case (st_q)
                LCO_S_IDLE:
                begin
                    quo_q <= NW'(nmag) * NW'(`LCO_UA_SPAN);
                    rem_q <= '0;
                    div_q <= dmag;
                    diff_q <= diff;
                    neg_q <= diff[DW] ^ den[DW];
                    cnt_q <= 6'(NW);
                    st_q <= LCO_S_RUN;
                end
                LCO_S_RUN:
                begin
                    if (rem_sh >= {1'b0, div_q})
                    begin
                        rem_q <= rem_sh - {1'b0, div_q};
                        quo_q <= {quo_q[NW-2:0], 1'b1};
                    end
                    else
                    begin
                        rem_q <= rem_sh;
                        quo_q <= {quo_q[NW-2:0], 1'b0};
                    end
                    cnt_q <= cnt_q - 6'h01;
                    if (cnt_q == 6'h01)
                        st_q <= LCO_S_DONE;
                end
                LCO_S_DONE:
                begin
                    if (div_q == '0)
                        lin_q <= $signed(`LCO_UA_LOW);
                    else if (neg_q)
                        lin_q <= $signed(`LCO_UA_LOW) - $signed(qsat);
                    else
                        lin_q <= $signed(`LCO_UA_LOW) + $signed(qsat);
                    st_q <= LCO_S_IDLE;
                end
            endcase
        end
    end

    // output selection by priority
    assign brk_force = en_q && input_type == LCO_IN_LOOP && input_break_flag;
    assign flt_force = input_type == LCO_IN_RTD && fsel_q != LCO_F_OFF && rtd_fault_q;

    always_comb
    begin
        if (!en_q || brk_force)
            out_d = `LCO_UA_DIS;
        else if (flt_force)
        begin
            unique case (fsel_q)
                LCO_F_3M6: out_d = `LCO_UA_3M6;
                LCO_F_3M8: out_d = `LCO_UA_MIN;
                default: out_d = `LCO_UA_21M;
            endcase
        end
        else if (lin_q < $signed(`LCO_UA_MIN))
            out_d = `LCO_UA_MIN;
        else if (lin_q > $signed(`LCO_UA_MAX))
            out_d = `LCO_UA_MAX;
        else
            out_d = lin_q;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_q <= `LCO_UA_DIS;
        else
            out_q <= out_d;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_disabled_level: assert property (!en_q |=> out_q == `LCO_UA_DIS)
        else $error("disabled output not at 3.5 mA");
    a_break_level: assert property (brk_force |=> out_q == `LCO_UA_DIS)
        else $error("input break did not force 3.5 mA");
    a_cal_disable: assert property (input_cal_changed |=> !en_q ##1 out_q == `LCO_UA_DIS)
        else $error("calibration change left output enabled");
    a_enable_keeps_ends: assert property ($changed(en_q) |-> $stable(low_q) && $stable(high_q))
        else $error("enable change altered endpoints");
    a_fault_force: assert property (en_q && !brk_force && flt_force && fsel_q == LCO_F_21M
        |=> out_q == `LCO_UA_21M)
        else $error("sensor fault current not forced");
    a_nonrtd_clamp: assert property (en_q && !brk_force && input_type != LCO_IN_RTD
        |=> out_q >= `LCO_UA_MIN && out_q <= `LCO_UA_MAX)
        else $error("fault current used without thermometer input");
    a_clamp_range: assert property (en_q && !brk_force && !flt_force
        |=> out_q >= `LCO_UA_MIN && out_q <= `LCO_UA_MAX)
        else $error("output outside clamp range");
    a_rtd_limits: assert property (rtd_wiring == LCO_W3 && rtd_resistance > `LCO_OHM_3W_HI
        |=> rtd_fault_q)
        else $error("resistance above limit not flagged");
    a_low_end: assert property (st_q == LCO_S_DONE && diff_q == '0 && div_q != '0
        |=> lin_q == $signed(`LCO_UA_LOW))
        else $error("low endpoint not at 4 mA");
    a_high_end: assert property (st_q == LCO_S_DONE && !neg_q && diff_q == div_q && div_q != '0
        |=> lin_q == $signed(`LCO_UA_HIGH))
        else $error("high endpoint not at 20 mA");
    a_track_lin: assert property (en_q && !brk_force && !flt_force && lin_q >= $signed(`LCO_UA_MIN)
        && lin_q <= $signed(`LCO_UA_MAX) |=> out_q == $past(lin_q))
        else $error("output does not follow display");
    a_bvalid_hold: assert property (bvalid_q && !bready |=> bvalid_q)
        else $error("write response dropped");

    c_enable: cover property (!en_q ##1 en_q);
    c_fault_21: cover property (en_q && flt_force && fsel_q == LCO_F_21M);
    c_break: cover property (brk_force);
endmodule
`default_nettype wire

// >>> sim/lco_loop_rx.sv
// current loop receiving indicator at the far side of the output stage
`timescale 1ns/1ps
`default_nettype none
module lco_loop_rx (
    input wire logic aclk,
    input wire logic [15:0] loop_current_ua,
    output logic [15:0] reading_ua
);
    // indicator samples the loop current once per clock
    always_ff @(posedge aclk)
    begin
        reading_ua <= loop_current_ua;
    end
endmodule
`default_nettype wire

// >>> sim/loop_current_output_control_bench.sv
// testbench for the loop current output controller
`timescale 1ns/1ps
`default_nettype none
`include "lco_defs.svh"
module loop_current_output_control_bench;
    import lco_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, sensor_fault;
    logic brk = 1'h0, cal = 1'h0;
    logic [3:0] strb = 4'hF;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [23:0] disp = 24'h0;
    logic [15:0] res = 16'h0064, loop_current_ua, seen;
    lco_in_t in_t = LCO_IN_VOLT;
    lco_wire_t wir = LCO_W3;
    int errors = 0, checked = 0, cycles = 0, i;
    logic [23:0] dv [9] = '{24'h0, 24'h320, 24'h321, 24'h640, 24'h672, 24'h673, 24'h7D0,
        24'hFFFFEC, 24'hFFFF9C};
    logic [15:0] ev [9] = '{16'h0FA0, 16'h2EE0, 16'h2EEA, 16'h4E20, 16'h5014, 16'h5014,
        16'h5014, 16'h0ED8, 16'h0ED8};
    logic [1:0] wl [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [15:0] rl [10] = '{16'h4, 16'h5, 16'h1F4, 16'h1F5, 16'h9, 16'hA, 16'h226, 16'h227,
        16'h9, 16'h227};
    logic fl [10] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    logic [15:0] fe [4] = '{16'h2EE0, 16'h0E10, 16'h0ED8, 16'h5208};

    always #12.5 aclk = ~aclk;

    lco_top #(.DW(24)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .display_value(disp), .input_type(in_t), .rtd_wiring(wir),
        .rtd_resistance(res), .input_break_flag(brk), .input_cal_changed(cal),
        .loop_current_ua(loop_current_ua), .sensor_fault(sensor_fault)
    );

    lco_loop_rx rx (
        .aclk(aclk),
        .loop_current_ua(loop_current_ua),
        .reading_ua(seen)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        awaddr <= a;
        wdata <= v;
        bready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        bready <= 1'h0;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        rready <= 1'h0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // two full divider passes let the output settle
    task automatic cur(input logic [15:0] e);
        repeat (100) @(posedge aclk);
        chk("loop current", {16'h0, e}, {16'h0, seen});
    endtask

    // reset for three cycles, then idle bus and disabled level at the first edge after it
    task automatic reset_pulse();
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("awready", 32'h1, {31'h0, awready});
        chk("wready", 32'h1, {31'h0, wready});
        chk("arready", 32'h1, {31'h0, arready});
        chk("bvalid", 32'h0, {31'h0, bvalid});
        chk("rvalid", 32'h0, {31'h0, rvalid});
        chk("reset current", 32'h0DAC, {16'h0, loop_current_ua});
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        reset_pulse();
        cur(16'h0DAC);
        rd(`LCO_OFF_STAT, 32'h0DAC, `LCO_RESP_OKAY);
        wr(`LCO_OFF_HIGH, 32'h640, `LCO_RESP_OKAY);
        wr(`LCO_OFF_CTRL, 32'h1, `LCO_RESP_OKAY);
        for (i = 0; i < 9; i++)
        begin
            disp <= dv[i];
            cur(ev[i]);
        end
        wr(`LCO_OFF_SEL, 32'h2, `LCO_RESP_OKAY);
        disp <= 24'hC80;
        cur(16'h2EE0);
        disp <= 24'hFFFE70;
        cur(16'h0ED8);
        wr(`LCO_OFF_SEL, 32'h0, `LCO_RESP_OKAY);
        disp <= 24'h7D0;
        wr(`LCO_OFF_CTRL, 32'h0, `LCO_RESP_OKAY);
        cur(16'h0DAC);
        rd(`LCO_OFF_LOW, 32'h0, `LCO_RESP_OKAY);
        rd(`LCO_OFF_HIGH, 32'h640, `LCO_RESP_OKAY);
        wr(`LCO_OFF_CTRL, 32'h1, `LCO_RESP_OKAY);
        cur(16'h5014);
        disp <= 24'h320;
        brk <= 1'h1;
        cur(16'h2EE0);
        in_t <= LCO_IN_LOOP;
        cur(16'h0DAC);
        rd(`LCO_OFF_STAT, 32'h0006_0DAC, `LCO_RESP_OKAY);
        brk <= 1'h0;
        cur(16'h2EE0);
        cal <= 1'h1;
        @(posedge aclk);
        cal <= 1'h0;
        cur(16'h0DAC);
        rd(`LCO_OFF_CTRL, 32'h0, `LCO_RESP_OKAY);
        in_t <= LCO_IN_RTD;
        for (i = 0; i < 10; i++)
        begin
            wir <= lco_wire_t'(wl[i]);
            res <= rl[i];
            repeat (3) @(posedge aclk);
            chk("sensor fault", {31'h0, fl[i]}, {31'h0, sensor_fault});
        end
        wir <= LCO_W3;
        res <= 16'h4;
        for (i = 0; i < 4; i++)
        begin
            wr(`LCO_OFF_CTRL, {29'h0, i[1:0], 1'h1}, `LCO_RESP_OKAY);
            cur(fe[i]);
        end
        rd(`LCO_OFF_STAT, 32'h0005_5208, `LCO_RESP_OKAY);
        in_t <= LCO_IN_VOLT;
        cur(16'h2EE0);
        in_t <= LCO_IN_RTD;
        wr(`LCO_OFF_CTRL, 32'h6, `LCO_RESP_OKAY);
        cur(16'h0DAC);
        rd(8'h14, 32'h0, `LCO_RESP_SLVERR);
        wr(8'h20, 32'h1, `LCO_RESP_SLVERR);
        wr(`LCO_OFF_STAT, 32'hFFFF_FFFF, `LCO_RESP_OKAY);
        rd(`LCO_OFF_CTRL, 32'h6, `LCO_RESP_OKAY);
        strb <= 4'h2;
        wr(`LCO_OFF_LOW, 32'hFFFF_12FF, `LCO_RESP_OKAY);
        rd(`LCO_OFF_LOW, 32'h0000_1200, `LCO_RESP_OKAY);
        strb <= 4'hF;
        reset_pulse();
        rd(`LCO_OFF_CTRL, 32'h0, `LCO_RESP_OKAY);
        rd(`LCO_OFF_LOW, 32'h0, `LCO_RESP_OKAY);
        rd(`LCO_OFF_HIGH, 32'h0, `LCO_RESP_OKAY);
        cur(16'h0DAC);
        test_done();
    end
endmodule
`default_nettype wire
